// [src/npc_ctrl.v]
// Notes on behaviour
// - Hold select high over 100ns to break
// - Never erase marks; scan into table first
// - Remap logical blocks around invalid ones
// - Status fail after program/erase: retire block
// - Single-bit errors fixed by correction code; controller has none, data read back uncorrected
// - Replace: page n, copy 1..n-1, mark old
// - Area A/C pointer before load command
// - Area B pointer right before load command
// - Select may idle between cycles, data kept
// - Load command, three addresses, then data
`timescale 1ns/1ps
`default_nettype none
`include "npc_regs.vh"
module npc_ctrl #(
  parameter FETCH_NS = `NPC_FETCH_NS,
  parameter NBLK     = 1024
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         nand_cle_o,
  output reg         nand_ale_o,
  output reg         nand_ce_n_o,
  output reg         nand_we_n_o,
  output reg         read_strobe_n_o,
  output reg  [7:0]  nand_io_o,
  output reg         nand_io_oe_o,
  input  wire [7:0]  nand_io_i,
  input  wire        nand_rb_i
);
  localparam integer STRB  = (`NPC_STROBE_NS + `NPC_CLK_NS - 1) / `NPC_CLK_NS;
  localparam integer BRK   = `NPC_SEQ_BRK_NS / `NPC_CLK_NS + 1;
  localparam integer GAP   = (`NPC_BUSY_GAP_NS + `NPC_CLK_NS - 1) / `NPC_CLK_NS;
  localparam integer FETCH = FETCH_NS / `NPC_CLK_NS;
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_LOW  = 3'h1;
  localparam [2:0] S_HIGH = 3'h2;
  localparam [2:0] S_GAP  = 3'h3;
  localparam [2:0] S_WAIT = 3'h4;
  localparam [2:0] S_DONE = 3'h5;

  // Bus request decode
  function is_adr;
    input [3:0] a;
    input [3:0] r;
    begin
      is_adr = (a == r);
    end
  endfunction

  wire [8:0]  pins_s;
  wire [7:0]  io_s  = pins_s[7:0];
  wire        rb_s  = pins_s[8];
  wire        tdone;
  reg         tload_r;
  reg  [15:0] tcnt_r;
  reg  [2:0]  st_r;
  reg  [2:0]  kind_r;
  reg  [7:0]  byte_r;
  reg  [7:0]  rdat_r;
  reg  [1:0]  ptr_r;
  reg         fail_r;
  reg         tout_r;
  reg  [NBLK-1:0] bad_r;
  reg  [9:0]  blk_r;
  wire        req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        busy = (st_r != S_IDLE);

  npc_sync #(.W(9)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({nand_rb_i, nand_io_i}),
    .q_o   (pins_s)
  );

  npc_timer #(.W(16)) u_tmr (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (tload_r),
    .count_i (tcnt_r),
    .done_o  (tdone)
  );

  // Wishbone slave and pin sequencer
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o        <= 1'b0;
      wb_dat_o        <= 32'h00000000;
      nand_cle_o      <= 1'b0;
      nand_ale_o      <= 1'b0;
      nand_ce_n_o     <= 1'b1;
      nand_we_n_o     <= 1'b1;
      read_strobe_n_o <= 1'b1;
      nand_io_o       <= 8'h00;
      nand_io_oe_o    <= 1'b0;
      st_r            <= S_IDLE;
      kind_r          <= `NPC_K_CMD;
      byte_r          <= 8'h00;
      rdat_r          <= 8'h00;
      ptr_r           <= `NPC_PTR_A;
      fail_r          <= 1'b0;
      tout_r          <= 1'b0;
      bad_r           <= {NBLK{1'b0}};
      blk_r           <= 10'h000;
      tload_r         <= 1'b0;
      tcnt_r          <= 16'h0000;
    end
    else
    begin
      wb_ack_o <= 1'b0;
      tload_r  <= 1'b0;
      if (req)
      begin
        wb_ack_o <= 1'b1;
        wb_dat_o <= 32'h00000000;
        if (is_adr(wb_adr_i, `NPC_ADR_CTRL))
        begin
          if (wb_we_i & wb_sel_i[1] & ~busy & wb_dat_i[`NPC_CTRL_GO])
          begin
            kind_r <= wb_dat_i[`NPC_CTRL_KIND_HI:`NPC_CTRL_KIND_LO];
            byte_r <= wb_dat_i[7:0];
            st_r   <= S_LOW;
            nand_ce_n_o <= 1'b0;
            tload_r <= 1'b1;
            tcnt_r  <= STRB[15:0];
          end
        end
        else if (is_adr(wb_adr_i, `NPC_ADR_ADDR))
        begin
          if (wb_we_i & wb_sel_i[1] & wb_sel_i[0])
          begin
            blk_r <= wb_dat_i[9:0];
            if (wb_dat_i[31] && wb_dat_i[9:0] != 10'h000)
              bad_r[wb_dat_i[9:0]] <= 1'b1;
          end
          else
            wb_dat_o <= {21'h000000, bad_r[blk_r], blk_r};
        end
        else if (is_adr(wb_adr_i, `NPC_ADR_DATA))
          wb_dat_o <= {22'h000000, (rdat_r != `NPC_ERASED), 1'b0, rdat_r};
        else if (is_adr(wb_adr_i, `NPC_ADR_STAT))
          wb_dat_o <= {26'h0000000, tout_r, ptr_r, fail_r, rb_s, busy};
      end
      // Pin phases
      case (st_r)
        S_IDLE:
        begin
          nand_we_n_o     <= 1'b1;
          read_strobe_n_o <= 1'b1;
        end
        S_LOW:
        begin
          case (kind_r)
            `NPC_K_CMD, `NPC_K_WAIT:
            begin
              nand_cle_o <= 1'b1;
              nand_we_n_o <= 1'b0;
              nand_io_o <= byte_r;
              nand_io_oe_o <= 1'b1;
              if (byte_r == `NPC_CMD_READ_B)
                ptr_r <= `NPC_PTR_B;
              else if (byte_r == `NPC_CMD_READ_C)
                ptr_r <= `NPC_PTR_C;
              else if (byte_r == `NPC_CMD_READ_A || byte_r == `NPC_CMD_RESET)
                ptr_r <= `NPC_PTR_A;
              else if (byte_r == `NPC_CMD_PROG || byte_r == `NPC_CMD_ERASE2)
                ptr_r <= (ptr_r == `NPC_PTR_B) ? `NPC_PTR_A : ptr_r;
            end
            `NPC_K_ADR:
            begin
              nand_ale_o <= 1'b1;
              nand_we_n_o <= 1'b0;
              nand_io_o <= byte_r;
              nand_io_oe_o <= 1'b1;
            end
            `NPC_K_WR:
            begin
              nand_we_n_o <= 1'b0;
              nand_io_o <= byte_r;
              nand_io_oe_o <= 1'b1;
            end
            `NPC_K_RD:
            begin
              nand_io_oe_o <= 1'b0;
              read_strobe_n_o <= 1'b0;
            end
            default:
              nand_io_oe_o <= 1'b0;
          endcase
          if (tdone)
          begin
            st_r    <= S_HIGH;
            tload_r <= 1'b1;
            tcnt_r  <= (kind_r == `NPC_K_RELSEL) ? BRK[15:0] : STRB[15:0];
            if (kind_r == `NPC_K_RELSEL)
              nand_ce_n_o <= 1'b1;
          end
        end
        S_HIGH:
        begin
          // Take read byte once it has crossed the synchroniser
          if (kind_r == `NPC_K_RD && tdone && !tload_r)
            rdat_r <= io_s;
          nand_we_n_o     <= 1'b1;
          read_strobe_n_o <= 1'b1;
          if (tdone && !tload_r)
          begin
            nand_cle_o   <= 1'b0;
            nand_ale_o   <= 1'b0;
            nand_io_oe_o <= 1'b0;
            tload_r      <= 1'b1;
            tcnt_r       <= GAP[15:0];
            st_r         <= (kind_r == `NPC_K_WAIT) ? S_GAP : S_DONE;
          end
        end
        S_GAP:
        begin
          // Busy may rise late; skip its delay before watching
          if (tdone && !tload_r)
          begin
            st_r    <= S_WAIT;
            tload_r <= 1'b1;
            tcnt_r  <= FETCH[15:0] + FETCH[15:0];
          end
        end
        S_WAIT:
        begin
          if (rb_s)
          begin
            st_r   <= S_DONE;
            tout_r <= 1'b0;
          end
          else if (tdone && !tload_r)
          begin
            st_r   <= S_DONE;
            tout_r <= 1'b1;
          end
        end
        S_DONE:
        begin
          // Status byte after program or erase
          if (kind_r == `NPC_K_RD && rdat_r[`NPC_SB_READY])
            fail_r <= rdat_r[`NPC_SB_FAIL];
          st_r <= S_IDLE;
        end
        default:
          st_r <= S_IDLE;
      endcase
    end
  end
endmodule // npc_ctrl
`default_nettype wire

// [src/npc_regs.vh]
`ifndef NPC_REGS_VH
`define NPC_REGS_VH
// Register byte addresses (controller's own)
`define NPC_ADR_CTRL     4'h0
`define NPC_ADR_ADDR     4'h4
`define NPC_ADR_DATA     4'h8
`define NPC_ADR_STAT     4'hC
// Control fields
`define NPC_CTRL_GO      8
`define NPC_CTRL_KIND_HI 11
`define NPC_CTRL_KIND_LO 9
// Operation kinds
`define NPC_K_CMD        3'h0
`define NPC_K_ADR        3'h1
`define NPC_K_WR         3'h2
`define NPC_K_RD         3'h3
`define NPC_K_WAIT       3'h4
`define NPC_K_RELSEL     3'h5
// Device commands
`define NPC_CMD_READ_A   8'h00
`define NPC_CMD_READ_B   8'h01
`define NPC_CMD_READ_C   8'h50
`define NPC_CMD_LOAD     8'h80
`define NPC_CMD_PROG     8'h10
`define NPC_CMD_ERASE1   8'h60
`define NPC_CMD_ERASE2   8'hD0
`define NPC_CMD_STATUS   8'h70
`define NPC_CMD_RESET    8'hFF
// Status bits from the device
`define NPC_SB_FAIL      0
`define NPC_SB_READY     6
// Device spare byte holding the factory bad mark
`define NPC_BAD_COL      10'd517
`define NPC_ERASED       8'hFF
// Pointer areas
`define NPC_PTR_A        2'h0
`define NPC_PTR_B        2'h1
`define NPC_PTR_C        2'h2
// Timing, ns, at 50 ns clock
`define NPC_CLK_NS       50
`define NPC_STROBE_NS    50
`define NPC_SEQ_BRK_NS   100
`define NPC_BUSY_GAP_NS  100
`define NPC_FETCH_NS     10000
`endif

// [src/npc_sync.v]
`timescale 1ns/1ps
`default_nettype none
module npc_sync #(
  parameter W = 9
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  // Two flip-flops for pin inputs
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end
    else
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule // npc_sync
`default_nettype wire

// [src/npc_timer.v]
`timescale 1ns/1ps
`default_nettype none
module npc_timer #(
  parameter W = 16
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         load_i,
  input  wire [W-1:0] count_i,
  output wire         done_o
);
  reg [W-1:0] cnt_r;
  // Down counter, done when zero
  always @(posedge clk_i)
  begin
    if (rst_i)
      cnt_r <= {W{1'b0}};
    else if (load_i)
      cnt_r <= count_i;
    else if (cnt_r != {W{1'b0}})
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
  end
  assign done_o = (cnt_r == {W{1'b0}});
endmodule // npc_timer
`default_nettype wire

// [tb/npc_ctrl_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module npc_ctrl_sva (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       nand_cle_o,
  input wire logic       nand_ale_o,
  input wire logic       nand_ce_n_o,
  input wire logic       nand_we_n_o,
  input wire logic       read_strobe_n_o,
  input wire logic [7:0] nand_io_o,
  input wire logic       nand_io_oe_o,
  input wire logic       nand_rb_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Pin and bus relations
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  property p_brk; $rose(nand_ce_n_o) |=> nand_ce_n_o [*2]; endproperty
  property p_wt; !nand_rb_i [*3] ##0 (nand_cle_o && !nand_we_n_o) |-> nand_io_o inside {8'h70, 8'hFF}; endproperty
  property p_mux; !(nand_cle_o && nand_ale_o); endproperty
  property p_str; !(!nand_we_n_o && !read_strobe_n_o); endproperty
  property p_drv; !nand_we_n_o |-> nand_io_oe_o; endproperty
  property p_oe; !read_strobe_n_o |-> !nand_io_oe_o; endproperty
  property p_sel; !nand_we_n_o || !read_strobe_n_o |-> !nand_ce_n_o; endproperty
  a_ack: assert property (p_ack) else $error("ack");
  a_brk: assert property (p_brk) else $error("select gap");
  a_wt: assert property (p_wt) else $error("busy cmd");
  a_mux: assert property (p_mux) else $error("latch mux");
  a_str: assert property (p_str) else $error("strobes");
  a_drv: assert property (p_drv) else $error("drive");
  a_oe: assert property (p_oe) else $error("contention");
  a_sel: assert property (p_sel) else $error("select");
endmodule // npc_ctrl_sva
bind npc_ctrl npc_ctrl_sva npc_ctrl_sva_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .nand_cle_o(nand_cle_o), .nand_ale_o(nand_ale_o),
  .nand_ce_n_o(nand_ce_n_o), .nand_we_n_o(nand_we_n_o), .read_strobe_n_o(read_strobe_n_o),
  .nand_io_o(nand_io_o), .nand_io_oe_o(nand_io_oe_o), .nand_rb_i(nand_rb_i));
`default_nettype wire

// [tb/npc_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module npc_dev #(
  parameter FETCH = 900,
  parameter RST   = 500,
  parameter BAD   = 3,
  parameter FB    = 1
) (
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       ce_n_i,
  input  wire logic       we_n_i,
  input  wire logic       re_n_i,
  input  wire logic [7:0] d_i,
  output var  logic [7:0] q_o,
  output var  logic       rb_o
);
  logic [7:0] cmd = 0, a1 = 0;
  logic [1:0] ptr = 0, n = 0;
  logic [9:0] col = 0;
  logic       fail = 0;
  int         dly = 0;
  initial rb_o = 1;
  initial q_o = 0;
  // Busy ends after the internal delay
  always @(negedge rb_o) rb_o <= #(dly) 1'b1;
  // Latch cycles on the write strobe
  always @(posedge we_n_i)
    if (!ce_n_i && cle_i)
    begin
      cmd <= d_i;
      n <= 0;
      if (d_i == 8'h00 || d_i == 8'hFF) ptr <= 0;
      if (d_i == 8'h01) ptr <= 1;
      if (d_i == 8'h50) ptr <= 2;
      if (d_i == 8'hFF) dly = RST;
      if (d_i == 8'h10) dly = FETCH;
      if (d_i == 8'hFF || d_i == 8'h10) rb_o <= 0;
      if (d_i == 8'h10) fail <= a1[7:5] == FB;
      if (d_i == 8'h10 && ptr == 1) ptr <= 0;
    end
    else if (!ce_n_i && ale_i)
    begin
      n <= n + 1;
      if (n == 0) col <= ptr == 2 ? {6'h20, d_i[3:0]} : {ptr, d_i};
      if (n == 1) a1 <= d_i;
      if (n == 2 && cmd != 8'h80) dly = FETCH;
      if (n == 2 && cmd != 8'h80) rb_o <= 0;
      if (n == 2 && ptr == 1) ptr <= 0;
    end
    else if (!ce_n_i) col <= col + 1;
  // Read data; block BAD carries the mark, block 0 never
  always @(negedge re_n_i)
    if (!ce_n_i)
    begin
      q_o <= cmd == 8'h70 ? {1'b1, rb_o, 5'h0, fail} : col == 10'd517 && a1[7:5] == BAD ? 8'h00 : 8'hFF;
      col <= col + 1;
    end
  // Released bus no longer shows data
  always @(posedge ce_n_i) q_o <= ~q_o;
endmodule // npc_dev
`default_nettype wire

// [tb/npc_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "npc_regs.vh"
module npc_ctrl_tb;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [3:0]  adr = 0;
  logic [31:0] wd = 0, rd, dat;
  logic        ack, cle, ale, ce_n, we_n, re_n, oe, rb;
  logic [7:0]  io_o, io_i;
  logic [7:0]  pc [8] = '{8'h50, 8'h80, 8'h10, 8'h01, 8'h10, 8'h01, 8'hFF, 8'h00};
  logic [1:0]  pe [8] = '{2, 2, 2, 1, 0, 1, 0, 0};
  int          num_errors = 0, compares = 0;
  always #25 clk_i = ~clk_i;
  npc_ctrl #(.FETCH_NS(1000)) npc_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .nand_cle_o(cle), .nand_ale_o(ale), .nand_ce_n_o(ce_n), .nand_we_n_o(we_n), .read_strobe_n_o(re_n),
    .nand_io_o(io_o), .nand_io_oe_o(oe), .nand_io_i(io_i), .nand_rb_i(rb));
  npc_dev npc_dev_i (.cle_i(cle), .ale_i(ale), .ce_n_i(ce_n), .we_n_i(we_n), .re_n_i(re_n), .d_i(io_o),
    .q_o(io_i), .rb_o(rb));
  task conclude;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  // Classic single Wishbone cycle
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    for (i = 0; i < 20 && !ack; i++) @(posedge clk_i);
    if (!ack) num_errors++;
    if (!ack) conclude;
    dat = rd;
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask
  // One byte operation, then wait idle and device ready
  task op(input logic [2:0] k, input logic [7:0] b);
    int i;
    bus(1, `NPC_ADR_CTRL, {20'h0, k, 1'b1, b});
    for (i = 0; i < 200 && (dat[0] || !dat[1]); i++) bus(0, `NPC_ADR_STAT, 0);
    if (i == 200) num_errors++;
    if (i == 200) conclude;
  endtask
  task rdb(input logic [7:0] c, ca, a1, input logic [9:0] e);
    op(`NPC_K_CMD, c);
    op(`NPC_K_ADR, ca);
    op(`NPC_K_ADR, a1);
    op(`NPC_K_ADR, 0);
    op(`NPC_K_RD, 0);
    bus(0, `NPC_ADR_DATA, 0);
    chk("data", e, {dat[9:8] & 2'h2, dat[7:0]});
  endtask
  initial
  begin
    repeat (50000) @(posedge clk_i);
    num_errors++;
    conclude;
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    bus(0, `NPC_ADR_STAT, 0);
    chk("ptr", 0, dat[4:3]);
    bus(1, 4'h2, 32'h1234);
    bus(0, 4'h2, 0);
    chk("unmapped", 0, dat);
    $display("reset test done");
    for (int j = 0; j < 8; j++)
    begin
      op(`NPC_K_CMD, pc[j]);
      bus(0, `NPC_ADR_STAT, 0);
      chk("ptr", pe[j], dat[4:3]);
    end
    op(`NPC_K_WAIT, 8'hFF);
    bus(0, `NPC_ADR_STAT, 0);
    chk("timeout", 0, dat[5]);
    $display("pointer test done");
    rdb(8'h00, 0, 8'h00, 10'h0FF);
    rdb(8'h50, 5, 8'h60, 10'h200);
    op(`NPC_K_RELSEL, 0);
    bus(1, `NPC_ADR_ADDR, 32'h8000_0003);
    bus(0, `NPC_ADR_ADDR, 0);
    chk("mark", 32'h0000_0403, dat);
    bus(1, `NPC_ADR_ADDR, 32'h8000_0000);
    bus(0, `NPC_ADR_ADDR, 0);
    chk("mark0", 0, dat);
    $display("read test done");
    op(`NPC_K_CMD, 8'h80);
    op(`NPC_K_ADR, 0);
    op(`NPC_K_ADR, 8'h20);
    op(`NPC_K_ADR, 0);
    op(`NPC_K_WR, 8'hA5);
    op(`NPC_K_CMD, 8'h10);
    op(`NPC_K_CMD, 8'h70);
    op(`NPC_K_RD, 0);
    bus(0, `NPC_ADR_STAT, 0);
    chk("fail", 3'h3, {dat[5], dat[2:1]});
    $display("program test done");
    conclude;
  end
endmodule // npc_ctrl_tb
`default_nettype wire
